// ---- low_io_pkg.sv ----
// Package: offsets, field layouts and reset values of the low bit-accessible I/O region
package low_io_pkg;
    localparam int unsigned   DATA_W             = 8;
    localparam int unsigned   IO_ADDR_W          = 6;
    localparam int unsigned   MEM_ADDR_W         = 7;
    localparam int unsigned   REG_COUNT          = 32;
    localparam logic [6:0]    DATA_SPACE_OFFSET  = 7'h20;
    localparam logic [5:0]    BIT_SPACE_LAST     = 6'h1f;
    localparam logic [7:0]    RESET_VALUE        = 8'h00;

    localparam logic [4:0]    ADC_CONTROL_B      = 5'h04;
    localparam logic [4:0]    ADC_CONTROL_A      = 5'h05;
    localparam logic [4:0]    CONV_RESULT_LOW    = 5'h06;
    localparam logic [4:0]    CONV_RESULT_HIGH   = 5'h07;
    localparam logic [4:0]    CONV_REF_GAIN_SEL  = 5'h08;
    localparam logic [4:0]    CONV_CHANNEL_SEL   = 5'h09;
    localparam logic [4:0]    COMP0_CONTROL_A    = 5'h0a;
    localparam logic [4:0]    COMP0_CONTROL_B    = 5'h0b;
    localparam logic [4:0]    COMP1_CONTROL_A    = 5'h0c;
    localparam logic [4:0]    COMP1_CONTROL_B    = 5'h0d;
    localparam logic [4:0]    TIMER1_EVENT_FLAGS = 5'h0e;
    localparam logic [4:0]    TIMER1_EVENT_EN    = 5'h0f;
    localparam logic [4:0]    TIMER2_EVENT_FLAGS = 5'h10;
    localparam logic [4:0]    TIMER2_EVENT_EN    = 5'h11;
    localparam logic [4:0]    PIN_CHANGE_MASK0   = 5'h12;
    localparam logic [4:0]    GP_STORE_0         = 5'h13;
    localparam logic [4:0]    GP_STORE_1         = 5'h14;
    localparam logic [4:0]    GP_STORE_2         = 5'h15;
    localparam logic [4:0]    PORT_B_INPUT       = 5'h16;
    localparam logic [4:0]    PORT_A_INPUT       = 5'h19;
    localparam logic [4:0]    PORT_A_DIRECTION   = 5'h1a;
    localparam logic [4:0]    PORT_A_OUTPUT      = 5'h1b;
    localparam logic [4:0]    NVM_CONTROL        = 5'h1c;
    localparam logic [4:0]    NVM_DATA_BYTE      = 5'h1d;
    localparam logic [4:0]    NVM_ADDRESS_LOW    = 5'h1e;
    localparam logic [4:0]    NVM_ADDRESS_HIGH   = 5'h1f;

    // Per-address masks: writable bits, write-one-to-clear flag bits, hardware-fed bits
    // Listed from address 0x1f down to 0x00, eight addresses a row
    localparam logic [255:0]  WRITABLE_MASKS     = {
        8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff, 8'h00, 8'h00,
        8'h00, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h27, 8'h27,
        8'h27, 8'h27, 8'hd4, 8'hdf, 8'hdf, 8'hdf, 8'h3f, 8'he3,
        8'h00, 8'h00, 8'hff, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [255:0]  W1C_MASKS          = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h27,
        8'h00, 8'h27, 8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [255:0]  HW_MASKS           = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
        8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h20, 8'h00, 8'h00,
        8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    typedef enum logic [3:0] {
        OP_IDLE  = 4'b0001,
        OP_READ  = 4'b0010,
        OP_WRITE = 4'b0100,
        OP_BIT   = 4'b1000
    } op_e;
endpackage : low_io_pkg

// ---- io_bit_cell.sv ----
// One register byte of the region: plain write, flag clear, bit set/clear and hardware update
`timescale 1ns/1ps
module io_bit_cell #(
    parameter logic [7:0] WR_MASK  = 8'h00,
    parameter logic [7:0] W1C_MASK = 8'h00,
    parameter logic [7:0] HW_MASK  = 8'h00
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_byte_we,
    input  wire logic [7:0] i_byte_data,
    input  wire logic       i_bit_we,
    input  wire logic [2:0] i_bit_sel,
    input  wire logic       i_bit_val,
    input  wire logic [7:0] i_hw_set,
    input  wire logic [7:0] i_hw_level,
    output logic      [7:0] o_value
);
    typedef struct packed {
        logic [7:0] value;
    } cell_s;

    cell_s cell_q;
    cell_s cell_d;
    logic [7:0] sel_onehot;

    always_comb begin
        cell_d     = cell_q;
        sel_onehot = 8'h01 << i_bit_sel;
        if (i_byte_we) begin
            cell_d.value = (cell_q.value & ~WR_MASK)
                         | (i_byte_data & WR_MASK & ~W1C_MASK);
            // Flags drop only where a one is written
            cell_d.value = cell_d.value | (cell_q.value & W1C_MASK & ~i_byte_data);
        end else if (i_bit_we && (sel_onehot & WR_MASK) != 8'h00) begin
            // Only the addressed bit moves; other pending flags stay untouched
            if ((sel_onehot & W1C_MASK) != 8'h00) begin
                if (i_bit_val) begin
                    cell_d.value = cell_q.value & ~sel_onehot;
                end
            end else if (i_bit_val) begin
                cell_d.value = cell_q.value | sel_onehot;
            end else begin
                cell_d.value = cell_q.value & ~sel_onehot;
            end
        end
        // Hardware events win over a clear in the same cycle
        cell_d.value = cell_d.value | (i_hw_set & W1C_MASK);
        cell_d.value = (cell_d.value & ~HW_MASK) | (i_hw_level & HW_MASK & ~W1C_MASK)
                     | (cell_d.value & HW_MASK & W1C_MASK);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cell_q <= '{value: 8'h00};
        end else begin
            cell_q <= cell_d;
        end
    end

    assign o_value = cell_q.value;
endmodule : io_bit_cell

// ---- low_io_bit_access_space.sv ----
// Top: low 32-byte I/O region with byte access, single-bit set/clear and bit test
//
// Summary of operation
// - Addresses 0x00-0x1F take single-bit set and clear; higher addresses refuse them.
// - The core can test one bit of a low register to decide a skip.
// - Status flags clear when written with one; writing zero leaves them.
// - Bit set or clear changes only the addressed bit, preserving other flags.
`timescale 1ns/1ps
module low_io_bit_access_space (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_io_rd,
    input  wire logic        i_io_wr,
    input  wire logic [5:0]  i_io_addr,
    input  wire logic        i_mem_rd,
    input  wire logic        i_mem_wr,
    input  wire logic [6:0]  i_mem_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_set_single_io_bit,
    input  wire logic        i_clear_single_io_bit,
    input  wire logic        i_skip_if_io_bit_one,
    input  wire logic        i_skip_if_io_bit_zero,
    input  wire logic [2:0]  i_bit_sel,
    input  wire logic [7:0]  i_port_b_pins,
    input  wire logic [7:0]  i_port_a_pins,
    input  wire logic [15:0] i_conversion_result,
    input  wire logic [7:0]  i_timer1_events,
    input  wire logic [7:0]  i_timer2_events,
    input  wire logic        i_comparator0_event,
    input  wire logic        i_comparator1_event,
    input  wire logic        i_conversion_done,
    input  wire logic [1:0]  i_comparator_outputs,
    output logic      [7:0]  o_rdata,
    output logic             o_rvalid,
    output logic             o_skip,
    output logic             o_bit_refused,
    output logic      [7:0]  o_port_a_direction,
    output logic      [7:0]  o_port_a_output_values
);
    typedef low_io_pkg::op_e op_state_t;
    typedef struct packed {
        logic [7:0] rdata;
        logic       rvalid;
        logic       skip;
        logic       bit_refused;
        op_state_t  op;
        logic [7:0] dir;
        logic [7:0] outv;
    } top_s;

    top_s top_q;
    top_s top_d;

    logic [7:0]  regs [0:31];
    logic [4:0]  sel_addr;
    logic        addr_ok;
    logic        is_rd;
    logic        is_wr;
    logic        bit_op;
    logic        bit_tst;
    logic [6:0]  mem_off;
    logic [7:0]  hw_set  [0:31];
    logic [7:0]  hw_lvl  [0:31];

    // Data-space path maps onto the same storage, offset by 0x20
    always_comb begin
        mem_off = i_mem_addr - low_io_pkg::DATA_SPACE_OFFSET;
        bit_op  = i_set_single_io_bit | i_clear_single_io_bit;
        bit_tst = i_skip_if_io_bit_one | i_skip_if_io_bit_zero;
        is_rd   = 1'b0;
        is_wr   = 1'b0;
        addr_ok = 1'b0;
        sel_addr = i_io_addr[4:0];
        if (i_io_rd | i_io_wr | bit_op | bit_tst) begin
            addr_ok = (i_io_addr <= low_io_pkg::BIT_SPACE_LAST);
            is_rd   = i_io_rd;
            is_wr   = i_io_wr;
        end else if (i_mem_rd | i_mem_wr) begin
            sel_addr = mem_off[4:0];
            addr_ok  = (i_mem_addr >= low_io_pkg::DATA_SPACE_OFFSET)
                     && (mem_off[6:5] == 2'b00);
            is_rd    = i_mem_rd;
            is_wr    = i_mem_wr;
        end
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            hw_set[i] = 8'h00;
            hw_lvl[i] = 8'h00;
        end
        hw_set[low_io_pkg::TIMER1_EVENT_FLAGS] = i_timer1_events;
        hw_set[low_io_pkg::TIMER2_EVENT_FLAGS] = i_timer2_events;
        hw_set[low_io_pkg::ADC_CONTROL_A]      = {3'h0, i_conversion_done, 4'h0};
        hw_set[low_io_pkg::COMP0_CONTROL_A]    = {3'h0, i_comparator0_event, 4'h0};
        hw_set[low_io_pkg::COMP1_CONTROL_A]    = {3'h0, i_comparator1_event, 4'h0};
        hw_lvl[low_io_pkg::CONV_RESULT_LOW]    = i_conversion_result[7:0];
        hw_lvl[low_io_pkg::CONV_RESULT_HIGH]   = i_conversion_result[15:8];
        hw_lvl[low_io_pkg::PORT_B_INPUT]       = {4'h0, i_port_b_pins[3:0]};
        hw_lvl[low_io_pkg::PORT_A_INPUT]       = i_port_a_pins;
        hw_lvl[low_io_pkg::COMP0_CONTROL_A]    = {2'h0, i_comparator_outputs[0], 5'h00};
        hw_lvl[low_io_pkg::COMP1_CONTROL_A]    = {2'h0, i_comparator_outputs[1], 5'h00};
    end

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_cell
            io_bit_cell #(
                .WR_MASK  (low_io_pkg::WRITABLE_MASKS[g*8 +: 8]),
                .W1C_MASK (low_io_pkg::W1C_MASKS[g*8 +: 8]),
                .HW_MASK  (low_io_pkg::HW_MASKS[g*8 +: 8])
            ) u_cell (
                .i_clk       (i_clk),
                .i_sys_rst   (i_sys_rst),
                .i_byte_we   (is_wr && addr_ok && sel_addr == g),
                .i_byte_data (i_wdata),
                .i_bit_we    (bit_op && addr_ok && sel_addr == g),
                .i_bit_sel   (i_bit_sel),
                .i_bit_val   (i_set_single_io_bit),
                .i_hw_set    (hw_set[g]),
                .i_hw_level  (hw_lvl[g]),
                .o_value     (regs[g])
            );
        end
    endgenerate

    always_comb begin
        top_d        = top_q;
        top_d.rvalid = 1'b0;
        top_d.skip   = 1'b0;
        top_d.bit_refused = 1'b0;
        top_d.op     = low_io_pkg::OP_IDLE;
        top_d.dir    = regs[low_io_pkg::PORT_A_DIRECTION];
        top_d.outv   = regs[low_io_pkg::PORT_A_OUTPUT];
        case (1'b1)
            bit_tst: begin
                top_d.op = low_io_pkg::OP_BIT;
                if (addr_ok) begin
                    // Skip when the chosen bit matches the tested sense
                    top_d.skip = i_skip_if_io_bit_one ? regs[sel_addr][i_bit_sel]
                                                      : ~regs[sel_addr][i_bit_sel];
                end else begin
                    top_d.bit_refused = 1'b1;
                end
            end
            bit_op: begin
                top_d.op = low_io_pkg::OP_BIT;
                top_d.bit_refused = ~addr_ok;
            end
            is_rd: begin
                top_d.op     = low_io_pkg::OP_READ;
                top_d.rvalid = 1'b1;
                top_d.rdata  = addr_ok ? regs[sel_addr] : 8'h00;
            end
            is_wr: begin
                top_d.op = low_io_pkg::OP_WRITE;
            end
            default: begin
                top_d.op = low_io_pkg::OP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            top_q <= '{rdata: 8'h00, rvalid: 1'b0, skip: 1'b0, bit_refused: 1'b0,
                       op: low_io_pkg::OP_IDLE, dir: 8'h00, outv: 8'h00};
        end else begin
            top_q <= top_d;
        end
    end

    assign o_rdata                = top_q.rdata;
    assign o_rvalid               = top_q.rvalid;
    assign o_skip                 = top_q.skip;
    assign o_bit_refused          = top_q.bit_refused;
    assign o_port_a_direction     = top_q.dir;
    assign o_port_a_output_values = top_q.outv;
endmodule : low_io_bit_access_space

// ---- low_io_sva.sv ----
// Checker: refusal, skip, single-bit and mirror timing at the region's ports
`timescale 1ns/1ps
module low_io_sva (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_io_rd,
    input wire logic       i_io_wr,
    input wire logic       i_mem_rd,
    input wire logic       i_mem_wr,
    input wire logic [5:0] i_io_addr,
    input wire logic [6:0] i_mem_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_set_single_io_bit,
    input wire logic       i_clear_single_io_bit,
    input wire logic       i_skip_if_io_bit_one,
    input wire logic       i_skip_if_io_bit_zero,
    input wire logic [2:0] i_bit_sel,
    input wire logic       o_rvalid,
    input wire logic       o_skip,
    input wire logic       o_bit_refused,
    input wire logic [7:0] o_port_a_output_values
);
    logic       tst;
    logic       bop;
    logic [7:0] pa;
    assign tst = i_skip_if_io_bit_one | i_skip_if_io_bit_zero;
    assign bop = i_set_single_io_bit | i_clear_single_io_bit;
    assign pa  = o_port_a_output_values;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    property p_refuse;
        (bop || tst) |=> o_bit_refused == $past(i_io_addr[5]);
    endproperty
    a_refuse: assert property (p_refuse) else $error("bit op refusal wrong");
    property p_quiet;
        !(bop || tst) |=> !o_bit_refused && !o_skip;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request");
    property p_skip_far;
        tst && i_io_addr[5] |=> !o_skip;
    endproperty
    a_skip_far: assert property (p_skip_far) else $error("skip out of range");
    // Port A copy lags the register by a cycle, hence the two-cycle reach
    property p_set;
        i_set_single_io_bit && !tst && i_io_addr == 6'h1b
            |-> ##2 pa == ($past(pa) | (8'h01 << $past(i_bit_sel, 2)));
    endproperty
    a_set: assert property (p_set) else $error("set touched other bits");
    property p_clr;
        i_clear_single_io_bit && !i_set_single_io_bit && !tst && i_io_addr == 6'h1b
            |-> ##2 pa == ($past(pa) & ~(8'h01 << $past(i_bit_sel, 2)));
    endproperty
    a_clr: assert property (p_clr) else $error("clear touched other bits");
    property p_mirror;
        i_mem_wr && i_mem_addr == 7'h3b && !bop && !tst && !i_io_wr && !i_io_rd
            |-> ##2 pa == $past(i_wdata, 2);
    endproperty
    a_mirror: assert property (p_mirror) else $error("data space write lost");
    property p_answer;
        (i_io_rd || i_mem_rd) && !bop && !tst |=> o_rvalid;
    endproperty
    a_answer: assert property (p_answer) else $error("read not answered");
endmodule : low_io_sva

// ---- core_model.sv ----
// Core model: issues one byte, bit or test request at a time
`timescale 1ns/1ps
module core_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    input  wire logic       i_skip,
    input  wire logic       i_bit_refused,
    output logic      [7:0] o_strobes,
    output logic      [6:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic      [2:0] o_bit_sel
);
    initial begin
        o_strobes = 8'h00;
        o_addr    = 7'h00;
        o_wdata   = 8'h00;
        o_bit_sel = 3'h0;
    end
    // Callers never write reserved places and keep reserved bits zero
    task automatic req(input logic [7:0] k, input logic [6:0] a, input logic [7:0] d,
                       input logic [2:0] b, output logic [10:0] got);
        @(posedge i_clk);
        o_strobes <= k;
        o_addr    <= a;
        o_wdata   <= d;
        o_bit_sel <= b;
        @(posedge i_clk);
        o_strobes <= 8'h00;
        o_addr    <= ~a;
        o_wdata   <= ~d;
        #1;
        got = {i_rvalid, i_skip, i_bit_refused, i_rdata};
    endtask : req
endmodule : core_model

// ---- tb.sv ----
// Testbench: byte, bit, test and mirror accesses through the core model
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] RD = 8'h01, WR = 8'h02, MRD = 8'h04, MWR = 8'h08;
    localparam logic [7:0] SET = 8'h10, CLR = 8'h20, SK1 = 8'h40, SK0 = 8'h80;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  stb, wd, rdata, pa_dir, pa_out, t1 = 8'h00, pins = 8'h00;
    logic [6:0]  addr;
    logic [2:0]  sel, ev = 3'h0;
    logic        rvalid, skip, refused;
    logic [10:0] got;
    int          fail_count = 0;
    int          tests_run = 0;
    always #10 clk = ~clk;
    core_model core (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .i_skip(skip),
        .i_bit_refused(refused), .o_strobes(stb), .o_addr(addr), .o_wdata(wd),
        .o_bit_sel(sel));
    low_io_bit_access_space dut (.i_clk(clk), .i_sys_rst(rst), .i_io_rd(stb[0]),
        .i_io_wr(stb[1]), .i_io_addr(addr[5:0]), .i_mem_rd(stb[2]), .i_mem_wr(stb[3]),
        .i_mem_addr(addr), .i_wdata(wd), .i_set_single_io_bit(stb[4]),
        .i_clear_single_io_bit(stb[5]), .i_skip_if_io_bit_one(stb[6]),
        .i_skip_if_io_bit_zero(stb[7]), .i_bit_sel(sel), .i_port_b_pins(~pins),
        .i_port_a_pins(pins), .i_conversion_result({pins, ~pins}), .i_timer1_events(t1),
        .i_timer2_events(t1), .i_comparator0_event(ev[0]), .i_comparator1_event(ev[1]),
        .i_conversion_done(ev[2]), .i_comparator_outputs(2'h0), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_skip(skip), .o_bit_refused(refused),
        .o_port_a_direction(pa_dir), .o_port_a_output_values(pa_out));
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Flags are always compared; the byte only when a read answer is expected
    task automatic op(input logic [7:0] k, input logic [6:0] a, input logic [7:0] d,
                      input logic [2:0] b, input logic [10:0] e);
        core.req(k, a, d, b, got);
        chk(e[10] ? got : {got[10:8], 8'h00}, e);
    endtask : op
    task automatic conclude;
        if (fail_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude
    initial begin
        repeat (2000) @(posedge clk);
        fail_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        op(WR, 7'h13, 8'h5a, 3'h0, 11'h000);
        op(MRD, 7'h33, 8'h00, 3'h0, 11'h45a);
        op(MWR, 7'h34, 8'ha5, 3'h0, 11'h000);
        op(RD, 7'h14, 8'h00, 3'h0, 11'h4a5);
        op(SET, 7'h13, 8'h00, 3'h2, 11'h000);
        op(CLR, 7'h13, 8'h00, 3'h6, 11'h000);
        op(RD, 7'h13, 8'h00, 3'h0, 11'h41e);
        op(SK1, 7'h13, 8'h00, 3'h1, 11'h200);
        op(SK1, 7'h13, 8'h00, 3'h0, 11'h000);
        op(SK0, 7'h13, 8'h00, 3'h0, 11'h200);
        op(SK0, 7'h13, 8'h00, 3'h4, 11'h000);
        for (int i = 4; i < 8; i++) op(8'h01 << i, 7'h20 + 7'(i), 8'h00, 3'h0, 11'h100);
        op(SET, 7'h1f, 8'h00, 3'h0, 11'h000);
        op(MWR, 7'h3b, 8'h81, 3'h0, 11'h000);
        op(SET, 7'h1b, 8'h00, 3'h3, 11'h000);
        op(CLR, 7'h1b, 8'h00, 3'h7, 11'h000);
        op(WR, 7'h1a, 8'h3c, 3'h0, 11'h000);
        op(RD, 7'h1b, 8'h00, 3'h0, 11'h409);
        chk({3'h0, pa_out}, 11'h009);
        chk({3'h0, pa_dir}, 11'h03c);
        pins <= 8'hc3;
        op(MRD, 7'h39, 8'h00, 3'h0, 11'h4c3);
        @(posedge clk);
        t1 <= 8'hff;
        ev <= 3'h1;
        @(posedge clk);
        t1 <= 8'h00;
        ev <= 3'h0;
        op(RD, 7'h0e, 8'h00, 3'h0, 11'h427);
        op(WR, 7'h0e, 8'h01, 3'h0, 11'h000);
        op(SET, 7'h0e, 8'h00, 3'h1, 11'h000);
        op(CLR, 7'h0e, 8'h00, 3'h2, 11'h000);
        op(WR, 7'h0e, 8'h00, 3'h0, 11'h000);
        op(RD, 7'h0e, 8'h00, 3'h0, 11'h424);
        op(MRD, 7'h30, 8'h00, 3'h0, 11'h427);
        op(RD, 7'h0a, 8'h00, 3'h0, 11'h410);
        op(SET, 7'h0a, 8'h00, 3'h4, 11'h000);
        op(RD, 7'h0a, 8'h00, 3'h0, 11'h400);
        conclude();
    end
endmodule : tb
bind low_io_bit_access_space low_io_sva sva (.i_clk, .i_sys_rst, .i_io_rd, .i_io_wr,
    .i_mem_rd, .i_mem_wr, .i_io_addr, .i_mem_addr, .i_wdata, .i_set_single_io_bit,
    .i_clear_single_io_bit, .i_skip_if_io_bit_one, .i_skip_if_io_bit_zero, .i_bit_sel,
    .o_rvalid, .o_skip, .o_bit_refused, .o_port_a_output_values);
